// >>> ecp_pkg.sv
// ecp_pkg: constants shared by the capture packetizer: register map, field
// positions, reset values, frame word codes and the emitter state encoding.
// assumes a single clock domain and the plain strobe register port.
package ecp_pkg;

    // ----------------------------------------------------------------
    // register map (byte offsets on the plain register port)
    // ----------------------------------------------------------------
    localparam logic [3:0]  REG_CTRL        = 4'h0;
    localparam logic [3:0]  REG_PKT_FRAMES  = 4'h4;
    localparam logic [3:0]  REG_STATUS      = 4'h8;
    localparam logic [3:0]  REG_FRAME_TOTAL = 4'hC;

    // control field positions and reset values
    localparam int          CTRL_EN_BIT      = 0;
    localparam int          CTRL_TTP_LSB     = 1;
    localparam int          CTRL_CONTENT_BIT = 3;
    localparam logic [3:0]  CTRL_RESET       = 4'h0;
    localparam logic [15:0] PKT_FRAMES_RESET = 16'h0001;

    // ----------------------------------------------------------------
    // channel word and frame identification word codes
    // ----------------------------------------------------------------
    localparam logic [3:0]  FORMAT_MAC       = 4'h0;
    localparam logic [8:0]  CHANNEL_SPEC_WORD_RSVD        = 9'h000;
    localparam logic [1:0]  TTP_FIRST_DA     = 2'h0;
    localparam logic [1:0]  TTP_LAST_FCS     = 2'h1;
    localparam logic [1:0]  TTP_FIRST_PAY    = 2'h2;
    localparam logic [1:0]  TTP_LAST_PAY     = 2'h3;
    localparam logic [1:0]  CONTENT_FULL     = 2'h0;
    localparam logic [1:0]  CONTENT_PAYLOAD  = 2'h1;
    localparam logic [3:0]  SPEED_AUTO       = 4'h0;
    localparam logic [3:0]  SPEED_MAX_CODE   = 4'h4;

    // frame length figures in bytes
    localparam logic [13:0] LEN_MIN          = 14'h0040;
    localparam logic [13:0] LEN_MAX          = 14'h05EE;
    localparam logic [13:0] PAYLOAD_OFFSET   = 14'h000E;
    localparam logic [13:0] MAC_OVERHEAD     = 14'h0012;
    localparam int          LEN_FIELD_MAX    = 16384;

    // ----------------------------------------------------------------
    // emitter states, gray coded along the usual path
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0000,
        ST_CHANNEL_SPEC_WORD_LO = 4'b0001,
        ST_CHANNEL_SPEC_WORD_HI = 4'b0011,
        ST_TS0     = 4'b0010,
        ST_TS1     = 4'b0110,
        ST_TS2     = 4'b0111,
        ST_TS3     = 4'b0101,
        ST_ID_LO   = 4'b0100,
        ST_ID_HI   = 4'b1100,
        ST_DATA    = 4'b1101
    } ecp_state_t;

endpackage : ecp_pkg

// >>> ecp_packetizer.sv
// ecp_packetizer: builds packet bodies of captured ethernet MAC frames as a
// stream of 16-bit words, plus the word FIFO that sits in the output path.
// assumes one clock, inputs synchronous to it, and a frame source that
// honours o_rx_ready.
//
// Contract
// - frames of many networks share packet, tagged
// - channel word opens every packet body
// - format field is always MAC code
// - time tag point code in bits 27-25
// - channel word bits 24-16 reserved, zero
// - frame count in channel word low half
// - each frame preceded by stamp and id
// - prefix is 12 bytes: low, high, id
// - 48-bit clock at reference, high zeroed
// - bit 31 flags frame CRC fault
// - bit 30 flags any frame fault
// - bits 29-28 give captured content extent
// - bits 27-24 give link speed code
// - bits 23-16 give network number
// - bit 15 flags payload CRC fault
// - bit 14 flags length outside 64-1518
// - bits 13-0 hold captured byte count
//
// The register addresses and the strobed register port are this design's own decisions.

// --------------------------------------------------------------------
// word FIFO
// --------------------------------------------------------------------
module ecp_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic      [WIDTH-1:0] o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("ecp_fifo depth must be a power of two, at least 2");
        end
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;
    logic             push;
    logic             pop;

    // full when pointers differ only in the wrap bit
    assign o_in_ready  = (wr_ptr_q ^ rd_ptr_q) != {1'b1, {AW{1'b0}}};
    assign o_out_valid = wr_ptr_q != rd_ptr_q;
    assign o_out_data  = mem_q[rd_ptr_q[AW-1:0]];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    // storage has no reset; only the pointers define occupancy
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_ptr_q[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end
endmodule : ecp_fifo

// --------------------------------------------------------------------
// packetizer top
// --------------------------------------------------------------------
module ecp_packetizer #(
    parameter int BUF_DEPTH  = 2048,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // register port
    input  wire logic [3:0]  i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    input  wire logic        i_reg_write,
    input  wire logic        i_reg_read,
    output logic      [31:0] o_reg_rdata,
    // free running 48-bit relative clock
    input  wire logic [47:0] i_rtc,
    // captured frame bytes from the monitored networks
    input  wire logic        i_rx_valid,
    input  wire logic [7:0]  i_rx_byte,
    input  wire logic        i_rx_last,
    input  wire logic [7:0]  i_rx_network_number,
    input  wire logic [3:0]  i_rx_speed,
    input  wire logic        i_rx_frame_crc_fault,
    input  wire logic        i_rx_frame_fault,
    input  wire logic        i_rx_payload_crc_fault,
    output logic             o_rx_ready,
    // packet body word stream
    output logic      [15:0] o_word,
    output logic             o_word_valid,
    output logic             o_word_last,
    input  wire logic        i_word_ready
);
    localparam int AW = $clog2(BUF_DEPTH);

    initial begin
        if (BUF_DEPTH < 2048 || BUF_DEPTH > ecp_pkg::LEN_FIELD_MAX
            || (1 << AW) != BUF_DEPTH) begin
            $error("ecp_packetizer buffer depth must be a power of two, 2048..16384");
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [3:0]  ctrl_q;
    logic [15:0] pkt_frames_cfg_q;
    logic [15:0] frame_total_q;
    logic [15:0] pkt_frames_q;
    logic [15:0] frames_done_q;
    logic        pkt_open_q;
    logic        held_q;
    logic        emit_done;

    wire logic       cfg_en      = ctrl_q[ecp_pkg::CTRL_EN_BIT];
    wire logic [1:0] cfg_ttp     = ctrl_q[ecp_pkg::CTRL_TTP_LSB +: 2];
    wire logic       cfg_payload = ctrl_q[ecp_pkg::CTRL_CONTENT_BIT];

    // software writes; zero frames per packet would never close a packet
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_q           <= ecp_pkg::CTRL_RESET;
            pkt_frames_cfg_q <= ecp_pkg::PKT_FRAMES_RESET;
        end else if (i_reg_write) begin
            if (i_reg_addr == ecp_pkg::REG_CTRL) begin
                ctrl_q <= i_reg_wdata[3:0];
            end
            if (i_reg_addr == ecp_pkg::REG_PKT_FRAMES && i_reg_wdata[15:0] != 16'h0000) begin
                pkt_frames_cfg_q <= i_reg_wdata[15:0];
            end
        end
    end

    // read data stands in the cycle after the strobe only; unmapped reads zero
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_reg_rdata <= 32'h0000_0000;
        end else if (!i_reg_read) begin
            o_reg_rdata <= 32'h0000_0000;
        end else begin
            unique case (i_reg_addr)
                ecp_pkg::REG_CTRL:        o_reg_rdata <= {28'h0000000, ctrl_q};
                ecp_pkg::REG_PKT_FRAMES:  o_reg_rdata <= {16'h0000, pkt_frames_cfg_q};
                ecp_pkg::REG_STATUS:      o_reg_rdata <= {14'h0000, held_q, pkt_open_q,
                                                          frames_done_q};
                ecp_pkg::REG_FRAME_TOTAL: o_reg_rdata <= {16'h0000, frame_total_q};
                default:                  o_reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // frame capture into the byte buffer
    // ----------------------------------------------------------------
    logic [7:0]  buf_q [BUF_DEPTH];
    logic [13:0] len_q;
    logic        ovf_q;
    logic [47:0] hist_q [4];
    logic [47:0] stamp_q;
    logic [31:0] id_q;
    logic        accept;
    logic [13:0] mac_len;
    logic [3:0]  speed_code;

    assign accept     = i_rx_valid && o_rx_ready;
    assign mac_len    = cfg_payload ? len_q + ecp_pkg::MAC_OVERHEAD : len_q;
    // reserved speed codes are never emitted; they fall back to auto
    assign speed_code = (i_rx_speed > ecp_pkg::SPEED_MAX_CODE) ? ecp_pkg::SPEED_AUTO
                                                                : i_rx_speed;

    // bytes beyond the buffer are dropped and the frame marked faulty
    always_ff @(posedge i_clk) begin
        if (accept && !ovf_q) begin
            buf_q[len_q[AW-1:0]] <= i_rx_byte;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            len_q <= 14'h0000;
            ovf_q <= 1'b0;
        end else if (emit_done) begin
            len_q <= 14'h0000;
            ovf_q <= 1'b0;
        end else if (accept && !ovf_q) begin
            len_q <= len_q + 14'h0001;
            ovf_q <= (len_q == 14'(BUF_DEPTH - 1)) && !i_rx_last;
        end
    end

    // per-byte stamp history, so the last payload byte can be found 4 back
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < 4; i++) begin
                hist_q[i] <= 48'h0000_0000_0000;
            end
        end else if (accept) begin
            hist_q[0] <= i_rtc;
            for (int i = 1; i < 4; i++) begin
                hist_q[i] <= hist_q[i-1];
            end
        end
    end

    // sample the clock at the chosen reference point of the frame
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            stamp_q <= 48'h0000_0000_0000;
        end else if (accept) begin
            if (len_q == 14'h0000 && (cfg_ttp == ecp_pkg::TTP_FIRST_DA
                || (cfg_ttp == ecp_pkg::TTP_FIRST_PAY && cfg_payload))) begin
                stamp_q <= i_rtc;
            end
            if (len_q == ecp_pkg::PAYLOAD_OFFSET && cfg_ttp == ecp_pkg::TTP_FIRST_PAY
                && !cfg_payload) begin
                stamp_q <= i_rtc;
            end
            if (i_rx_last && (cfg_ttp == ecp_pkg::TTP_LAST_FCS
                || (cfg_ttp == ecp_pkg::TTP_LAST_PAY && cfg_payload))) begin
                stamp_q <= i_rtc;
            end else if (i_rx_last && cfg_ttp == ecp_pkg::TTP_LAST_PAY) begin
                stamp_q <= hist_q[3]; // full frame: skip the 4 check-sequence bytes
            end
        end
    end

    // identification word, built on the last byte of the frame
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            id_q <= 32'h0000_0000;
        end else if (accept && i_rx_last) begin
            id_q[31]    <= i_rx_frame_crc_fault;
            id_q[30]    <= i_rx_frame_fault || ovf_q;
            id_q[29:28] <= cfg_payload ? ecp_pkg::CONTENT_PAYLOAD
                                       : ecp_pkg::CONTENT_FULL;
            id_q[27:24] <= speed_code;
            id_q[23:16] <= i_rx_network_number;
            id_q[15]    <= i_rx_payload_crc_fault;
            id_q[14]    <= ovf_q || (mac_len + 14'h0001) < ecp_pkg::LEN_MIN
                           || (mac_len + 14'h0001) > ecp_pkg::LEN_MAX;
            id_q[13:0]  <= ovf_q ? len_q : len_q + 14'h0001;
        end
    end

    // one frame held at a time; ready is a flop that drops after the last byte
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            held_q     <= 1'b0;
            o_rx_ready <= 1'b0;
        end else begin
            if (accept && i_rx_last) begin
                held_q <= 1'b1;
            end else if (emit_done) begin
                held_q <= 1'b0;
            end
            o_rx_ready <= cfg_en && !(accept && i_rx_last) && !(held_q && !emit_done);
        end
    end

    // ----------------------------------------------------------------
    // emitter
    // ----------------------------------------------------------------
    ecp_pkg::ecp_state_t state_q;
    logic [13:0] rd_q;
    logic [15:0] word_d;
    logic        last_d;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic        step;
    logic        data_end;
    logic        pkt_end;
    logic [31:0] channel_spec_word;
    logic [7:0]  hi_byte;

    assign channel_spec_word = {ecp_pkg::FORMAT_MAC,
                   1'b0, cfg_ttp,
                   ecp_pkg::CHANNEL_SPEC_WORD_RSVD,
                   pkt_frames_q};
    assign fifo_in_valid = state_q != ecp_pkg::ST_IDLE;
    assign step          = fifo_in_valid && fifo_in_ready;
    assign data_end      = (state_q == ecp_pkg::ST_DATA && rd_q + 14'h0002 >= id_q[13:0])
                           || (state_q == ecp_pkg::ST_ID_HI && id_q[13:0] == 14'h0000);
    assign emit_done     = step && data_end;
    assign pkt_end       = frames_done_q + 16'h0001 == pkt_frames_q;
    // odd count: the high half of the final word is filler
    assign hi_byte       = (rd_q + 14'h0001 < id_q[13:0]) ? buf_q[AW'(rd_q + 14'h0001)]
                                                           : 8'h00;

    // word selection per state; the 12-byte prefix is six words in order
    always_comb begin
        word_d = 16'h0000;
        last_d = data_end && pkt_end;
        unique case (state_q)
            ecp_pkg::ST_IDLE:    word_d = 16'h0000;
            ecp_pkg::ST_CHANNEL_SPEC_WORD_LO: word_d = channel_spec_word[15:0];
            ecp_pkg::ST_CHANNEL_SPEC_WORD_HI: word_d = channel_spec_word[31:16];
            ecp_pkg::ST_TS0:     word_d = stamp_q[15:0];
            ecp_pkg::ST_TS1:     word_d = stamp_q[31:16];
            ecp_pkg::ST_TS2:     word_d = stamp_q[47:32];
            ecp_pkg::ST_TS3:     word_d = 16'h0000;
            ecp_pkg::ST_ID_LO:   word_d = id_q[15:0];
            ecp_pkg::ST_ID_HI:   word_d = id_q[31:16];
            ecp_pkg::ST_DATA:    word_d = {hi_byte, buf_q[rd_q[AW-1:0]]};
        endcase
    end

    // sequencing: a held frame opens a packet if none is open, else joins it
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= ecp_pkg::ST_IDLE;
            rd_q    <= 14'h0000;
        end else begin
            unique case (state_q)
                ecp_pkg::ST_IDLE: begin
                    rd_q <= 14'h0000;
                    if (held_q) begin
                        state_q <= pkt_open_q ? ecp_pkg::ST_TS0 : ecp_pkg::ST_CHANNEL_SPEC_WORD_LO;
                    end
                end
                ecp_pkg::ST_CHANNEL_SPEC_WORD_LO: if (step) state_q <= ecp_pkg::ST_CHANNEL_SPEC_WORD_HI;
                ecp_pkg::ST_CHANNEL_SPEC_WORD_HI: if (step) state_q <= ecp_pkg::ST_TS0;
                ecp_pkg::ST_TS0:     if (step) state_q <= ecp_pkg::ST_TS1;
                ecp_pkg::ST_TS1:     if (step) state_q <= ecp_pkg::ST_TS2;
                ecp_pkg::ST_TS2:     if (step) state_q <= ecp_pkg::ST_TS3;
                ecp_pkg::ST_TS3:     if (step) state_q <= ecp_pkg::ST_ID_LO;
                ecp_pkg::ST_ID_LO:   if (step) state_q <= ecp_pkg::ST_ID_HI;
                ecp_pkg::ST_ID_HI: begin
                    if (step) begin
                        state_q <= data_end ? ecp_pkg::ST_IDLE : ecp_pkg::ST_DATA;
                    end
                end
                ecp_pkg::ST_DATA: begin
                    if (step) begin
                        rd_q <= rd_q + 14'h0002;
                        if (data_end) begin
                            state_q <= ecp_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // packet bookkeeping; the frame count is fixed when the packet opens
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pkt_open_q    <= 1'b0;
            pkt_frames_q  <= ecp_pkg::PKT_FRAMES_RESET;
            frames_done_q <= 16'h0000;
            frame_total_q <= 16'h0000;
        end else begin
            if (state_q == ecp_pkg::ST_IDLE && held_q && !pkt_open_q) begin
                pkt_open_q    <= 1'b1;
                pkt_frames_q  <= pkt_frames_cfg_q;
                frames_done_q <= 16'h0000;
            end else if (emit_done) begin
                frame_total_q <= frame_total_q + 16'h0001;
                if (pkt_end) begin
                    pkt_open_q    <= 1'b0;
                    frames_done_q <= 16'h0000;
                end else begin
                    frames_done_q <= frames_done_q + 16'h0001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // output FIFO and registered output stage
    // ----------------------------------------------------------------
    logic        fifo_out_valid;
    logic [16:0] fifo_out_data;
    logic        fifo_out_ready;

    assign fifo_out_ready = !o_word_valid || i_word_ready;

    ecp_fifo #(
        .WIDTH (17),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_in_valid  (fifo_in_valid),
        .i_in_data   ({last_d, word_d}),
        .o_in_ready  (fifo_in_ready),
        .o_out_valid (fifo_out_valid),
        .o_out_data  (fifo_out_data),
        .i_out_ready (fifo_out_ready)
    );

    // output flops keep the stream outputs free of the FIFO's read mux
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_word       <= 16'h0000;
            o_word_last  <= 1'b0;
            o_word_valid <= 1'b0;
        end else if (fifo_out_ready) begin
            o_word_valid <= fifo_out_valid;
            o_word       <= fifo_out_data[15:0];
            o_word_last  <= fifo_out_data[16] && fifo_out_valid;
        end
    end
endmodule : ecp_packetizer

// >>> ecp_packetizer_monitor.sv
// ecp_packetizer_monitor: port checks on the packet body word stream and the frame input handshake.
// assumes one clock and an async active-high reset; bound by the bench.
module ecp_packetizer_monitor (
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_rx_valid,
    input wire logic        i_rx_last,
    input wire logic        o_rx_ready,
    input wire logic [15:0] o_word,
    input wire logic        o_word_valid,
    input wire logic        o_word_last,
    input wire logic        i_word_ready
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic [3:0] idx_q;
    logic       at0, at1, at5, at7;
    // ------------------------------------------------------------
    // word position in packet; saturates, so only the first prefix is seen
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset)
            idx_q <= 4'h0;
        else if (o_word_valid && i_word_ready)
            idx_q <= o_word_last ? 4'h0 : idx_q + {3'h0, idx_q != 4'hF};
    end
    assign at0 = o_word_valid && idx_q == 4'h0;
    assign at1 = o_word_valid && idx_q == 4'h1;
    assign at5 = o_word_valid && idx_q == 4'h5;
    assign at7 = o_word_valid && idx_q == 4'h7;
    a_word_hold: assert property (o_word_valid && !i_word_ready
        |=> o_word_valid && $stable(o_word) && $stable(o_word_last)) else $error("word moved");
    a_count_set: assert property (at0 |-> o_word != 16'h0000) else $error("no count");
    a_format_mac: assert property (at1 |-> o_word[15:12] == 4'h0) else $error("format");
    a_ttp_legal: assert property (at1 |-> !o_word[11]) else $error("time point");
    a_resv_zero: assert property (at1 |-> o_word[8:0] == 9'h000) else $error("reserved");
    a_stamp_top: assert property (at5 |-> o_word == 16'h0000) else $error("stamp top");
    a_content_code: assert property (at7 |-> !o_word[13]) else $error("content");
    a_speed_code: assert property (at7 |-> o_word[11:8] <= 4'h4) else $error("speed");
    a_frame_held: assert property (i_rx_valid && o_rx_ready && i_rx_last
        |=> !o_rx_ready [*3]) else $error("ready early");
    c_pkt_done: cover property (o_word_valid && i_word_ready && o_word_last);
    c_stall: cover property (o_word_valid && !i_word_ready);
    c_frame_in: cover property (i_rx_valid && o_rx_ready && i_rx_last);
endmodule : ecp_packetizer_monitor

// >>> ecp_frame_source.sv
// ecp_frame_source: model of the monitored networks handing over frame bytes.
// assumes send is called just after a rising edge; each byte held until taken.
module ecp_frame_source (
    input  wire logic        i_clk,
    input  wire logic        i_ready,
    output logic             o_valid,
    output logic      [7:0]  o_byte,
    output logic             o_last,
    output logic      [14:0] o_side
);
    int         seed = 43980;
    int         timeouts = 0;
    logic [7:0] sent[$];
    initial begin
        o_valid = 1'b0;
        o_byte = 8'h00;
        o_last = 1'b0;
        o_side = 15'h0000;
    end
    // released lines show the inverse, so a stale byte never looks valid
    task send(input int n, input int gap, input logic [14:0] sd);
        logic [7:0] b;
        int         w;
        sent.delete();
        for (int i = 0; i < n && timeouts == 0; i++) begin
            b = 8'($random(seed));
            sent.push_back(b);
            o_valid <= 1'b1;
            o_byte <= b;
            o_last <= (i == n - 1);
            o_side <= (i == n - 1) ? sd : ~sd;
            w = 0;
            do begin
                @(posedge i_clk);
                w++;
            end while (!i_ready && w < 3000);
            // a byte never taken is counted and the frame abandoned
            timeouts += int'(!i_ready);
            // valid drops only for a gap, at the end or after a timeout, never twice in one step
            if (gap > 0 || i == n - 1 || !i_ready) begin
                o_valid <= 1'b0;
                o_byte <= ~b;
            end
            repeat (gap) @(posedge i_clk);
        end
        o_last <= 1'b0;
        o_side <= ~sd;
    endtask : send
endmodule : ecp_frame_source

// >>> ecp_packetizer_test.sv
// ecp_packetizer_test: self-checking bench for the capture packetizer.
// assumes the frame source and monitor are compiled before this file.
module ecp_packetizer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, wrdy = 1'b0;
    logic        rxv, rxl, rxr, wv, wl;
    logic [3:0]  ra = 4'h0;
    logic [31:0] wd = 32'h0, rdata, id;
    logic [47:0] rtc = 48'hA5A500000000;
    logic [7:0]  rxb;
    logic [14:0] side, sd;
    logic [15:0] w;
    logic [16:0] xq[$];
    logic [47:0] tq[$];
    int          seed = 43980, num_errors = 0, cmp_count = 0, k = 0, p, n, r, m;
    ecp_frame_source src (.i_clk(clk), .i_ready(rxr), .o_valid(rxv), .o_byte(rxb),
        .o_last(rxl), .o_side(side));
    ecp_packetizer dut (.i_clk(clk), .i_reset(rst), .i_reg_addr(ra), .i_reg_wdata(wd),
        .i_reg_write(wr), .i_reg_read(rd), .o_reg_rdata(rdata), .i_rtc(rtc),
        .i_rx_valid(rxv), .i_rx_byte(rxb), .i_rx_last(rxl), .i_rx_network_number(side[14:7]),
        .i_rx_speed(side[6:3]), .i_rx_frame_crc_fault(side[2]), .i_rx_frame_fault(side[1]),
        .i_rx_payload_crc_fault(side[0]), .o_rx_ready(rxr), .o_word(w), .o_word_valid(wv),
        .o_word_last(wl), .i_word_ready(wrdy));
    initial forever #10 clk = ~clk;
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task end_of_test();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task rreg(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rreg
    // stalling sink, time source, byte time log and word comparison
    always @(posedge clk) begin
        rtc <= rtc + 48'h1;
        wrdy <= ($random(seed) % 4) != 0;
        if (rxv && rxr)
            tq.push_back(rtc);
        if (wv && wrdy)
            chk({15'h0, wl, w}, xq.size() ? {15'h0, xq.pop_front()} : 32'hFFFFFFFF);
    end
    initial begin
        int len[12] = '{63, 64, 3, 1519, 1518, 20, 45, 46, 1, 2, 7, 1500};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rreg(4'h4, 32'h1);
        wreg(4'h4, 32'h0);
        rreg(4'h4, 32'h1);
        rreg(4'h2, 32'h0);
        // eight setups: every time point, both extents, one and two frames
        for (int c = 0; c < 8; c++) begin
            p = 1 + c % 2;
            wreg(4'h4, 32'(p));
            wreg(4'h0, {28'h0, c[2], c[1:0], 1'b1});
            for (int f = 0; f < p; f++) begin
                n = len[k];
                sd = {8'($random(seed)), 4'(k % 6), 3'(k)};
                src.send(n, k % 3, sd);
                if (src.timeouts != 0) begin
                    num_errors++;
                    end_of_test();
                end
                // one edge more so the last byte's time is logged
                @(posedge clk);
                r = c[1:0] == 0 ? 0 : c[1:0] == 1 ? n - 1 : c[1:0] == 2 ? (c[2] ? 0 : 14)
                    : (c[2] ? n - 1 : n - 5);
                m = n + (c[2] ? 18 : 0);
                id = {sd[2:1], 1'b0, c[2], sd[6:3] > 4 ? 4'h0 : sd[6:3], sd[14:7], sd[0],
                    m < 64 || m > 1518, 14'(n)};
                if (f == 0) begin
                    xq.push_back({1'b0, 16'(p)});
                    xq.push_back({6'h0, c[1:0], 9'h0});
                end
                xq.push_back({1'b0, tq[r][15:0]});
                xq.push_back({1'b0, tq[r][31:16]});
                xq.push_back({1'b0, tq[r][47:32]});
                xq.push_back(17'h0);
                xq.push_back({1'b0, id[15:0]});
                xq.push_back({1'b0, id[31:16]});
                for (int i = 0; i < n; i += 2)
                    xq.push_back({f == p - 1 && i + 2 >= n, i + 1 < n ? src.sent[i + 1] : 8'h00,
                        src.sent[i]});
                tq.delete();
                k++;
            end
            for (int t = 0; t < 5000 && xq.size() > 0; t++)
                @(posedge clk);
            if (xq.size() > 0) begin
                num_errors++;
                end_of_test();
            end
        end
        rreg(4'hC, 32'h0000000C);
        rreg(4'h0, 32'h0000000F);
        rreg(4'h8, 32'h00000000);
        end_of_test();
    end
endmodule : ecp_packetizer_test

bind ecp_packetizer ecp_packetizer_monitor mon (.i_clk(i_clk), .i_reset(i_reset),
    .i_rx_valid(i_rx_valid), .i_rx_last(i_rx_last), .o_rx_ready(o_rx_ready), .o_word(o_word),
    .o_word_valid(o_word_valid), .o_word_last(o_word_last), .i_word_ready(i_word_ready));
